//--- ppct_edge_detect.sv
// Edge detector: pulse on rising, falling or both edges of a level.
// Assumes the level is synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
`include "ppct_regs.svh"
module ppct_edge_detect (
    input  wire logic       sys_clk,
    input  wire logic       rstSyncB,
    input  wire logic       level,
    input  wire logic [1:0] edgeSel,
    output logic            pulse
);
    logic prevReg;
    wire  riseSeen = level & ~prevReg;
    wire  fallSeen = ~level & prevReg;

    always_ff @(posedge sys_clk or negedge rstSyncB) begin
        if (!rstSyncB) begin
            prevReg <= 1'b0;
        end else begin
            prevReg <= level;
        end
    end

    // Code 1x takes both edges, 01 falling, 00 rising
    assign pulse = edgeSel[1] ? (riseSeen | fallSeen) : (edgeSel[0] ? fallSeen : riseSeen);
endmodule
`default_nettype wire

//--- ppct_pkg.sv
// Types shared by the capture timer files.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package ppct_pkg;
    typedef logic [7:0]  ppct_byte_t;
    typedef logic [15:0] ppct_word_t;
    typedef logic [12:0] ppct_psc_t;
    typedef enum logic [2:0] {
        PPCT_CLK_DIV1    = 3'b000,
        PPCT_CLK_DIV8A   = 3'b001,
        PPCT_CLK_DIV2    = 3'b010,
        PPCT_CLK_DIV8B   = 3'b011,
        PPCT_CLK_DIV32   = 3'b100,
        PPCT_CLK_EXTA    = 3'b101,
        PPCT_CLK_DIV8192 = 3'b110,
        PPCT_CLK_EXTB    = 3'b111
    } ppct_clk_sel_e;
endpackage
`default_nettype wire

//--- ppct_pulse_source.sv
// Pulse source that stands in front of the capture pin.
// Assumes the pin is sampled on the rising edge of sys_clk.
`timescale 1ns/1ps
`default_nettype none
module ppct_pulse_source (
    input  wire logic       sys_clk,
    input  wire logic       pulseOn,
    input  wire logic [7:0] halfPeriod,
    output logic            pinOut
);
    // ----------------------------------------------------------------
    // Square wave
    // ----------------------------------------------------------------
    logic [7:0] phaseCnt;

    // A stopped source drives low, so no rising edge leaks out between runs
    always_ff @(posedge sys_clk) begin
        if (!pulseOn) begin
            pinOut   <= 1'b0;
            phaseCnt <= 8'h00;
        end else if (phaseCnt == halfPeriod - 8'h01) begin
            pinOut   <= ~pinOut;
            phaseCnt <= 8'h00;
        end else begin
            phaseCnt <= phaseCnt + 8'h01;
        end
    end
endmodule
`default_nettype wire

//--- ppct_regs.svh
// Register offsets, field positions, codes and reset values of the capture timer.
// Assumes an 8-bit register port with 16-bit byte addresses.
`ifndef PPCT_REGS_SVH
`define PPCT_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PPCT_ADDR_CTRL   16'hf700
`define PPCT_ADDR_IOCTL  16'hf701
`define PPCT_ADDR_STATUS 16'hf703
`define PPCT_ADDR_IRQEN  16'hf704
`define PPCT_ADDR_CNT_HI 16'hf706
`define PPCT_ADDR_CNT_LO 16'hf707
`define PPCT_ADDR_GRA_HI 16'hf708
`define PPCT_ADDR_GRA_LO 16'hf709
`define PPCT_ADDR_START  16'hf720
`define PPCT_ADDR_MODE   16'hf721
`define PPCT_ADDR_FUNC   16'hf722

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PPCT_CLKSEL   2:0
`define PPCT_CNTEDGE  4:3
`define PPCT_CCLR     7:5
`define PPCT_IOMODE   2:0
`define PPCT_IOEDGE   1:0
`define PPCT_IOCAP    2
`define PPCT_OVF_BIT  4
`define PPCT_CAPF_BIT 0
`define PPCT_OVERFLOW_IRQ_ENABLE_BIT 7
`define PPCT_CAPIE_BIT 0
`define PPCT_RUN0_BIT 0
`define PPCT_SYNC_BIT 0
`define PPCT_BYTE_HI  15:8
`define PPCT_BYTE_LO  7:0

// ----------------------------------------------------------------
// Writable bit masks and codes
// ----------------------------------------------------------------
`define PPCT_MASK_IOCTL 8'h07
`define PPCT_MASK_IRQEN 8'h81
`define PPCT_MASK_START 8'h03
`define PPCT_MASK_MODE  8'h01
`define PPCT_MASK_FUNC  8'h13
`define PPCT_CCLR_GRA   3'b001
`define PPCT_TAP_DIV2    0
`define PPCT_TAP_DIV8    2
`define PPCT_TAP_DIV32   4
`define PPCT_TAP_DIV8192 12

// ----------------------------------------------------------------
// Reset values and steps
// ----------------------------------------------------------------
`define PPCT_RESET_BYTE 8'h00
`define PPCT_RESET_WORD 16'h0000
`define PPCT_PSC_RESET  13'h0000
`define PPCT_PSC_STEP   13'h0001
`define PPCT_CNT_STEP   16'h0001
`define PPCT_CNT_MAX    16'hffff
`define PPCT_SYNC_RESET 2'b00

`endif

//--- ppct_timer.sv
// Pulse period capture timer: prescaler, channel counter, capture register A,
// status and enable flags, start, mode and combination registers.
// Assumes a byte register port and a capture pin synchronous to sys_clk.
//
// Operation
// - A 13-bit prescaler steps every clock and feeds the counter clock taps.
// - A readable, writable 16-bit up counter steps on the chosen count clock.
// - Control bits 2..0 pick the count clock; codes 001 and 011 give clock over eight.
// - Control bits 4..3 pick the count edge; 00 counts rising edges.
// - Control bits 7..5 equal 001 clear the counter on register A events.
// - I/O control bits 2..0 equal 100 capture on capture pin rising edge.
// - On the chosen capture edge the counter is copied into register A.
// - Every capture into register A sets capture flag A.
// - A status register holds the capture A flag and the overflow flag.
// - Enable bits each allow or block the request of their status flag.
// - A start register holds separate run bits for both channel counters; here only bit 0 runs the one counter, bit 1 is only stored and read back.
// - A mode bit makes the counter run synchronous or independent of channel one; here the bit is only stored and read back.
// - A function register selects combination modes and an output level; here it is only stored and read back, with no output.
// - Clock over eight gives the stated count step and longest period.
// - Overflow flag sits at status bit 4, capture flag A at bit 0.
// - Overflow enable sits at bit 7, capture A enable at bit 0.
// - Start bit 0 low stops the counter, high runs it.
// - Mode bit 0 low means independent, high means synchronous; the code only stores the bit.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "ppct_regs.svh"
module ppct_timer (
    input  wire logic                sys_clk,
    input  wire logic                rst_b,
    input  wire logic [15:0]         regAddr,
    input  wire ppct_pkg::ppct_byte_t regWrData,
    input  wire logic                regWrStb,
    input  wire logic                regRdStb,
    output ppct_pkg::ppct_byte_t     regRdData,
    input  wire logic                capturePinA,
    input  wire logic                extCountClk,
    output logic                     irqReq
);
    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic [1:0] rstSyncReg;
    wire        rstSyncB = rstSyncReg[1];

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rstSyncReg <= `PPCT_SYNC_RESET;
        end else begin
            rstSyncReg <= {rstSyncReg[0], 1'b1};
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    ppct_pkg::ppct_psc_t  systemPrescalerReg;
    ppct_pkg::ppct_byte_t channelControlReg;
    ppct_pkg::ppct_byte_t captureIoControlAReg;
    ppct_pkg::ppct_byte_t channelStatusReg;
    ppct_pkg::ppct_byte_t channelIrqEnableReg;
    ppct_pkg::ppct_byte_t counterStartReg;
    ppct_pkg::ppct_byte_t counterModeReg;
    ppct_pkg::ppct_byte_t combinationFunctionReg;
    ppct_pkg::ppct_word_t channelCounterReg;
    ppct_pkg::ppct_word_t generalRegisterAReg;
    ppct_pkg::ppct_word_t channelCounterNext;
    ppct_pkg::ppct_word_t generalRegisterANext;
    ppct_pkg::ppct_byte_t channelStatusNext;
    ppct_pkg::ppct_byte_t regRdNext;
    logic                 irqReqNext;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    wire wrCtrl   = regWrStb & (regAddr == `PPCT_ADDR_CTRL);
    wire wrIoctl  = regWrStb & (regAddr == `PPCT_ADDR_IOCTL);
    wire wrStatus = regWrStb & (regAddr == `PPCT_ADDR_STATUS);
    wire wrIrqen  = regWrStb & (regAddr == `PPCT_ADDR_IRQEN);
    wire wrCntHi  = regWrStb & (regAddr == `PPCT_ADDR_CNT_HI);
    wire wrCntLo  = regWrStb & (regAddr == `PPCT_ADDR_CNT_LO);
    wire wrGraHi  = regWrStb & (regAddr == `PPCT_ADDR_GRA_HI);
    wire wrGraLo  = regWrStb & (regAddr == `PPCT_ADDR_GRA_LO);
    wire wrStart  = regWrStb & (regAddr == `PPCT_ADDR_START);
    wire wrMode   = regWrStb & (regAddr == `PPCT_ADDR_MODE);
    wire wrFunc   = regWrStb & (regAddr == `PPCT_ADDR_FUNC);
    wire cntWrite = wrCntHi | wrCntLo;

    // ----------------------------------------------------------------
    // Count clock selection
    // ----------------------------------------------------------------
    ppct_pkg::ppct_clk_sel_e clockSelect;
    logic                    tapLevel;
    logic                    tapEveryCycle;
    logic                    tapEdge;

    assign clockSelect = ppct_pkg::ppct_clk_sel_e'(channelControlReg[`PPCT_CLKSEL]);

    // Both printed codes for clock over eight are honoured, as the two disagree
    always_comb begin
        tapLevel      = 1'b0;
        tapEveryCycle = 1'b0;
        unique case (clockSelect)
            ppct_pkg::PPCT_CLK_DIV1:    tapEveryCycle = 1'b1;
            ppct_pkg::PPCT_CLK_DIV8A:   tapLevel = systemPrescalerReg[`PPCT_TAP_DIV8];
            ppct_pkg::PPCT_CLK_DIV2:    tapLevel = systemPrescalerReg[`PPCT_TAP_DIV2];
            ppct_pkg::PPCT_CLK_DIV8B:   tapLevel = systemPrescalerReg[`PPCT_TAP_DIV8];
            ppct_pkg::PPCT_CLK_DIV32:   tapLevel = systemPrescalerReg[`PPCT_TAP_DIV32];
            ppct_pkg::PPCT_CLK_EXTA:    tapLevel = extCountClk;
            ppct_pkg::PPCT_CLK_DIV8192: tapLevel = systemPrescalerReg[`PPCT_TAP_DIV8192];
            ppct_pkg::PPCT_CLK_EXTB:    tapLevel = extCountClk;
        endcase
    end

    ppct_edge_detect countEdgeDetect (
        .sys_clk  (sys_clk),
        .rstSyncB (rstSyncB),
        .level    (tapLevel),
        .edgeSel  (channelControlReg[`PPCT_CNTEDGE]),
        .pulse    (tapEdge)
    );

    // Sync bit only joins a second channel, which this block does not hold
    wire channelRun = counterStartReg[`PPCT_RUN0_BIT];
    wire countTick  = channelRun & (tapEveryCycle | tapEdge);

    // ----------------------------------------------------------------
    // Capture and compare on register A
    // ----------------------------------------------------------------
    logic capEdge;

    ppct_edge_detect captureEdgeDetect (
        .sys_clk  (sys_clk),
        .rstSyncB (rstSyncB),
        .level    (capturePinA),
        .edgeSel  (captureIoControlAReg[`PPCT_IOEDGE]),
        .pulse    (capEdge)
    );

    wire captureMode = captureIoControlAReg[`PPCT_IOCAP];
    wire capEvent    = captureMode & capEdge;
    wire cmpEvent    = ~captureMode & countTick & (channelCounterReg == generalRegisterAReg);
    wire graEvent    = capEvent | cmpEvent;
    wire clrOnGra    = graEvent & (channelControlReg[`PPCT_CCLR] == `PPCT_CCLR_GRA);
    wire atMax       = channelCounterReg == `PPCT_CNT_MAX;
    wire ovfSet      = countTick & atMax & ~cntWrite & ~clrOnGra;

    // ----------------------------------------------------------------
    // Next values
    // ----------------------------------------------------------------
    // Software write beats clear and count, so a loaded value is never lost
    assign channelCounterNext =
        wrCntHi  ? {regWrData, channelCounterReg[`PPCT_BYTE_LO]} :
        wrCntLo  ? {channelCounterReg[`PPCT_BYTE_HI], regWrData} :
        clrOnGra ? `PPCT_RESET_WORD :
        countTick ? channelCounterReg + `PPCT_CNT_STEP :
        channelCounterReg;

    // A capture beats a software write in the same cycle
    assign generalRegisterANext =
        capEvent ? channelCounterReg :
        wrGraHi  ? {regWrData, generalRegisterAReg[`PPCT_BYTE_LO]} :
        wrGraLo  ? {generalRegisterAReg[`PPCT_BYTE_HI], regWrData} :
        generalRegisterAReg;

    // Writing 0 clears a flag; an event in the same cycle wins
    wire ovfKeep  = channelStatusReg[`PPCT_OVF_BIT] & ~(wrStatus & ~regWrData[`PPCT_OVF_BIT]);
    wire capfKeep = channelStatusReg[`PPCT_CAPF_BIT] & ~(wrStatus & ~regWrData[`PPCT_CAPF_BIT]);

    always_comb begin
        channelStatusNext = `PPCT_RESET_BYTE;
        channelStatusNext[`PPCT_OVF_BIT]  = ovfSet | ovfKeep;
        channelStatusNext[`PPCT_CAPF_BIT] = graEvent | capfKeep;
    end

    wire ovfReq  = channelStatusReg[`PPCT_OVF_BIT] & channelIrqEnableReg[`PPCT_OVERFLOW_IRQ_ENABLE_BIT];
    wire capfReq = channelStatusReg[`PPCT_CAPF_BIT] & channelIrqEnableReg[`PPCT_CAPIE_BIT];
    assign irqReqNext = ovfReq | capfReq;

    // Unmapped addresses read as zero
    assign regRdNext =
        ~regRdStb ? `PPCT_RESET_BYTE :
        (regAddr == `PPCT_ADDR_CTRL)   ? channelControlReg :
        (regAddr == `PPCT_ADDR_IOCTL)  ? captureIoControlAReg :
        (regAddr == `PPCT_ADDR_STATUS) ? channelStatusReg :
        (regAddr == `PPCT_ADDR_IRQEN)  ? channelIrqEnableReg :
        (regAddr == `PPCT_ADDR_CNT_HI) ? channelCounterReg[`PPCT_BYTE_HI] :
        (regAddr == `PPCT_ADDR_CNT_LO) ? channelCounterReg[`PPCT_BYTE_LO] :
        (regAddr == `PPCT_ADDR_GRA_HI) ? generalRegisterAReg[`PPCT_BYTE_HI] :
        (regAddr == `PPCT_ADDR_GRA_LO) ? generalRegisterAReg[`PPCT_BYTE_LO] :
        (regAddr == `PPCT_ADDR_START)  ? counterStartReg :
        (regAddr == `PPCT_ADDR_MODE)   ? counterModeReg :
        (regAddr == `PPCT_ADDR_FUNC)   ? combinationFunctionReg :
        `PPCT_RESET_BYTE;

    // ----------------------------------------------------------------
    // Flip-flops
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstSyncB) begin
        if (!rstSyncB) begin
            systemPrescalerReg <= `PPCT_PSC_RESET;
        end else begin
            systemPrescalerReg <= systemPrescalerReg + `PPCT_PSC_STEP;
        end
    end

    always_ff @(posedge sys_clk or negedge rstSyncB) begin
        if (!rstSyncB) begin
            channelControlReg    <= `PPCT_RESET_BYTE;
            captureIoControlAReg <= `PPCT_RESET_BYTE;
            channelIrqEnableReg  <= `PPCT_RESET_BYTE;
        end else begin
            if (wrCtrl) begin
                channelControlReg <= regWrData;
            end
            if (wrIoctl) begin
                captureIoControlAReg <= regWrData & `PPCT_MASK_IOCTL;
            end
            if (wrIrqen) begin
                channelIrqEnableReg <= regWrData & `PPCT_MASK_IRQEN;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstSyncB) begin
        if (!rstSyncB) begin
            counterStartReg        <= `PPCT_RESET_BYTE;
            counterModeReg         <= `PPCT_RESET_BYTE;
            combinationFunctionReg <= `PPCT_RESET_BYTE;
        end else begin
            if (wrStart) begin
                counterStartReg <= regWrData & `PPCT_MASK_START;
            end
            if (wrMode) begin
                counterModeReg <= regWrData & `PPCT_MASK_MODE;
            end
            if (wrFunc) begin
                combinationFunctionReg <= regWrData & `PPCT_MASK_FUNC;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstSyncB) begin
        if (!rstSyncB) begin
            channelCounterReg   <= `PPCT_RESET_WORD;
            generalRegisterAReg <= `PPCT_RESET_WORD;
            channelStatusReg    <= `PPCT_RESET_BYTE;
            irqReq              <= 1'b0;
            regRdData           <= `PPCT_RESET_BYTE;
        end else begin
            channelCounterReg   <= channelCounterNext;
            generalRegisterAReg <= generalRegisterANext;
            channelStatusReg    <= channelStatusNext;
            irqReq              <= irqReqNext;
            regRdData           <= regRdNext;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstSyncB);

    a_prescaler_step: assert property (
        $past(rstSyncB) |-> systemPrescalerReg == $past(systemPrescalerReg) + `PPCT_PSC_STEP)
        else $error("prescaler did not step");

    a_capture_copy: assert property (
        capEvent |=> generalRegisterAReg == $past(channelCounterReg))
        else $error("capture did not copy counter");

    a_capture_flag_set: assert property (
        graEvent |=> channelStatusReg[`PPCT_CAPF_BIT])
        else $error("capture flag not set");

    a_capture_clears_cnt: assert property (
        capEvent && !cntWrite && channelControlReg[`PPCT_CCLR] == `PPCT_CCLR_GRA
        |=> channelCounterReg == `PPCT_RESET_WORD)
        else $error("counter not cleared on capture");

    a_overflow_wrap: assert property (
        countTick && atMax && !cntWrite && !clrOnGra
        |=> channelCounterReg == `PPCT_RESET_WORD && channelStatusReg[`PPCT_OVF_BIT])
        else $error("counter did not wrap with overflow");

    a_stopped_holds: assert property (
        !channelRun && !cntWrite && !clrOnGra |=> $stable(channelCounterReg))
        else $error("stopped counter moved");

    a_div8_cadence: assert property (
        channelRun && clockSelect == ppct_pkg::PPCT_CLK_DIV8A
        && channelControlReg[`PPCT_CNTEDGE] == 2'b00 && countTick ##1
        $stable(channelControlReg) [*7] |-> !$past(countTick))
        else $error("divide by eight cadence broken");

    a_irq_follows: assert property (
        (ovfReq || capfReq) |=> irqReq)
        else $error("request missing while flag enabled");

    a_irq_drops: assert property (
        !(ovfReq || capfReq) |=> !irqReq)
        else $error("request without enabled flag");

    a_flag_set_wins: assert property (
        ovfSet && wrStatus |=> channelStatusReg[`PPCT_OVF_BIT])
        else $error("overflow lost against clear");

    a_read_idle_zero: assert property (
        !regRdStb |=> regRdData == `PPCT_RESET_BYTE)
        else $error("read data not zero outside a read");

    a_status_readback: assert property (
        regRdStb && regAddr == `PPCT_ADDR_STATUS |=> regRdData == $past(channelStatusReg))
        else $error("status read returned wrong value");

    a_counter_step: assert property (
        countTick && !cntWrite && !clrOnGra && !atMax
        |=> channelCounterReg == $past(channelCounterReg) + `PPCT_CNT_STEP)
        else $error("counter did not step on tick");

    a_irqen_written: assert property (
        wrIrqen |=> channelIrqEnableReg == ($past(regWrData) & `PPCT_MASK_IRQEN))
        else $error("enable register took wrong bits");

    a_start_written: assert property (
        wrStart |=> counterStartReg == ($past(regWrData) & `PPCT_MASK_START))
        else $error("start register took wrong bits");

    a_compare_no_capture: assert property (
        !captureMode && !wrGraHi && !wrGraLo |=> $stable(generalRegisterAReg))
        else $error("register A changed outside capture");

    a_overflow_only_wrap: assert property (
        !ovfSet && !channelStatusReg[`PPCT_OVF_BIT] |=> !channelStatusReg[`PPCT_OVF_BIT])
        else $error("overflow flag set without wrap");

    c_capture_seen: cover property (capEvent ##[1:20] capEvent);
    c_overflow_seen: cover property (ovfSet);
    c_irq_raised: cover property (capfReq ##1 irqReq);
    c_flag_cleared: cover property (channelStatusReg[`PPCT_CAPF_BIT] ##1 !channelStatusReg[`PPCT_CAPF_BIT]);
endmodule
`default_nettype wire

//--- pulse_period_capture_timer_bench.sv
// Self-checking bench of the capture timer: register port, rates, overflow, capture.
// Assumes the pulse source model and the register header beside it.
`timescale 1ns/1ps
`default_nettype none
`include "ppct_regs.svh"
`define CHECK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin fails++; \
    $display("Error %s expected %h seen %h", what, exp, got); end end
module pulse_period_capture_timer_bench;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic                 sys_clk;
    logic                 rst_b;
    logic [15:0]          regAddr;
    ppct_pkg::ppct_byte_t regWrData;
    logic                 regWrStb;
    logic                 regRdStb;
    ppct_pkg::ppct_byte_t regRdData;
    logic                 capturePinA;
    logic                 irqReq;
    logic                 pulseOn;
    logic [7:0]           halfPeriod;
    int                   fails;
    int                   comparisons;

    ppct_timer uut (.sys_clk(sys_clk), .rst_b(rst_b), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
        .regRdData(regRdData), .capturePinA(capturePinA), .extCountClk(1'b0),
        .irqReq(irqReq));
    ppct_pulse_source source (.sys_clk(sys_clk), .pulseOn(pulseOn),
        .halfPeriod(halfPeriod), .pinOut(capturePinA));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // ----------------------------------------------------------------
    // Bus tasks
    // ----------------------------------------------------------------
    task automatic wr(input logic [15:0] a, input ppct_pkg::ppct_byte_t d);
        @(posedge sys_clk);
        regWrStb  <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge sys_clk);
        regWrStb  <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, output ppct_pkg::ppct_byte_t d);
        @(posedge sys_clk);
        regRdStb <= 1'b1;
        regAddr  <= a;
        @(posedge sys_clk);
        regRdStb <= 1'b0;
        #1 d = regRdData;
    endtask

    // High byte first; only used on a stopped counter so the pair cannot tear
    task automatic rdw(input logic [15:0] a, output ppct_pkg::ppct_word_t w);
        rd(a, w[15:8]);
        rd(a + 16'h0001, w[7:0]);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic test_masks();
        logic [15:0]          addrs [6];
        ppct_pkg::ppct_byte_t masks [6];
        ppct_pkg::ppct_byte_t d;
        addrs = '{`PPCT_ADDR_CTRL, `PPCT_ADDR_IOCTL, `PPCT_ADDR_IRQEN,
                  `PPCT_ADDR_START, `PPCT_ADDR_MODE, `PPCT_ADDR_FUNC};
        masks = '{8'hff, `PPCT_MASK_IOCTL, `PPCT_MASK_IRQEN,
                  `PPCT_MASK_START, `PPCT_MASK_MODE, `PPCT_MASK_FUNC};
        for (int i = 0; i < 6; i++) begin
            rd(addrs[i], d);
            `CHECK("reset value", 8'h00, d)
            wr(addrs[i], 8'hff);
            rd(addrs[i], d);
            `CHECK("written bits", masks[i], d)
            wr(addrs[i], 8'h00);
        end
        wr(16'hf702, 8'hff);
        rd(16'hf702, d);
        `CHECK("unmapped read", 8'h00, d)
        `CHECK("irq after reset", 1'b0, irqReq)
    endtask

    // Run a clock select for a fixed span and compare the count
    task automatic test_rates();
        logic [2:0]          sels [5];
        int                  divs [5];
        ppct_pkg::ppct_word_t w;
        ppct_pkg::ppct_word_t w2;
        int                  want;
        sels = '{3'b000, 3'b001, 3'b011, 3'b010, 3'b100};
        divs = '{1, 8, 8, 2, 32};
        for (int i = 0; i < 5; i++) begin
            wr(`PPCT_ADDR_CTRL, {5'h00, sels[i]});
            wr(`PPCT_ADDR_CNT_HI, 8'h00);
            wr(`PPCT_ADDR_CNT_LO, 8'h00);
            wr(`PPCT_ADDR_START, 8'h01);
            repeat (128) @(posedge sys_clk);
            wr(`PPCT_ADDR_START, 8'h00);
            rdw(`PPCT_ADDR_CNT_HI, w);
            want = 130 / divs[i];
            // Tap phase may add or drop one count at either end
            `CHECK("rate count", 1'b1, (int'(w) >= want - 1) && (int'(w) <= want + 1))
            repeat (40) @(posedge sys_clk);
            rdw(`PPCT_ADDR_CNT_HI, w2);
            `CHECK("stopped counter", w, w2)
        end
    endtask

    task automatic test_overflow();
        ppct_pkg::ppct_byte_t d;
        wr(`PPCT_ADDR_CTRL, 8'h00);
        // Compare matches at zero leave flag A set; capture mode on an idle pin stops them
        wr(`PPCT_ADDR_IOCTL, 8'h04);
        wr(`PPCT_ADDR_STATUS, 8'h00);
        wr(`PPCT_ADDR_IRQEN, 8'h80);
        wr(`PPCT_ADDR_CNT_HI, 8'hff);
        wr(`PPCT_ADDR_CNT_LO, 8'hf0);
        wr(`PPCT_ADDR_START, 8'h01);
        repeat (30) @(posedge sys_clk);
        wr(`PPCT_ADDR_START, 8'h00);
        rd(`PPCT_ADDR_STATUS, d);
        `CHECK("overflow flag", 8'h10, d)
        rd(`PPCT_ADDR_CNT_HI, d);
        `CHECK("wrapped high byte", 8'h00, d)
        `CHECK("overflow irq", 1'b1, irqReq)
        wr(`PPCT_ADDR_IRQEN, 8'h00);
        repeat (2) @(negedge sys_clk);
        `CHECK("masked irq", 1'b0, irqReq)
        wr(`PPCT_ADDR_STATUS, 8'h00);
        rd(`PPCT_ADDR_STATUS, d);
        `CHECK("flags cleared", 8'h00, d)
    endtask

    task automatic test_capture();
        ppct_pkg::ppct_word_t w;
        ppct_pkg::ppct_byte_t d;
        wr(`PPCT_ADDR_CTRL, {`PPCT_CCLR_GRA, 5'h00});
        wr(`PPCT_ADDR_IOCTL, 8'h04);
        wr(`PPCT_ADDR_IRQEN, 8'h01);
        wr(`PPCT_ADDR_START, 8'h01);
        halfPeriod <= 8'd25;
        pulseOn    <= 1'b1;
        repeat (140) @(posedge sys_clk);
        pulseOn    <= 1'b0;
        wr(`PPCT_ADDR_START, 8'h00);
        rdw(`PPCT_ADDR_GRA_HI, w);
        // Cleared at each capture, so a 50-cycle period reads back one less
        `CHECK("captured period", 16'h0031, w)
        rd(`PPCT_ADDR_STATUS, d);
        `CHECK("capture flag", 8'h01, d)
        `CHECK("capture irq", 1'b1, irqReq)
        wr(`PPCT_ADDR_STATUS, 8'h00);
        repeat (2) @(negedge sys_clk);
        `CHECK("irq dropped", 1'b0, irqReq)
        wr(`PPCT_ADDR_IOCTL, 8'h00);
        pulseOn <= 1'b1;
        repeat (80) @(posedge sys_clk);
        pulseOn <= 1'b0;
        rd(`PPCT_ADDR_STATUS, d);
        `CHECK("no capture when off", 8'h00, d)
    endtask

    // ----------------------------------------------------------------
    // Verdict and run
    // ----------------------------------------------------------------
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // The whole run is about 1300 cycles; this leaves a wide margin
    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        print_verdict();
    end

    initial begin
        fails       = 0;
        comparisons = 0;
        rst_b       = 1'b0;
        regAddr     = 16'h0000;
        regWrData   = 8'h00;
        regWrStb    = 1'b0;
        regRdStb    = 1'b0;
        pulseOn     = 1'b0;
        halfPeriod  = 8'd25;
        repeat (6) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge sys_clk);
        test_masks();
        test_rates();
        test_overflow();
        test_capture();
        print_verdict();
    end
endmodule
`default_nettype wire
